// ===== core/sec_core.sv
// serial eeprom command core: link front end, array and write cycle
`timescale 1ns/1ps
`include "sec_params.svh"
module sec_core import sec_pkg::*; #(
  parameter int ADDR_W = `SEC_ADDR_W,
  parameter int PAGE_W = `SEC_PAGE_W,
  parameter int WRITE_CYCLES = `SEC_TWC_NS / `SEC_CLK_NS
) (
  // system
  input wire logic clk_sys,
  input wire logic rst,
  // serial link
  input wire logic sckClk,
  input wire logic csN,
  input wire logic siData,
  input wire logic holdN,
  input wire logic wpN,
  output logic soData,
  output logic soOe,
  // status
  output logic writeBusyBit,
  output logic writeLatchBit,
  output logic blockProtectLow,
  output logic blockProtectHigh,
  output logic protectPinEnable
);
  localparam int PAGE_SIZE = 1 << PAGE_W;
  localparam int TW = $clog2(WRITE_CYCLES + 1);

  function automatic logic isProtected(input logic [ADDR_W-1:0] a, input logic [1:0] bp);
    case (bp)
      2'h1: return a >= `SEC_QTR_BASE;
      2'h2: return a >= `SEC_HALF_BASE;
      2'h3: return 1'h1;
      default: return 1'h0;
    endcase
  endfunction : isProtected

  // array; read from the link side only while no write cycle runs
  logic [7:0] mem [PAGE_SIZE << (ADDR_W - PAGE_W)];
  logic [7:0] pageBuf [PAGE_SIZE];

  // ---------------- link clock domain ----------------
  sec_phase_type phase_q, phase_d, curPhase;
  sec_frame_type frame_q, frame_d;
  sec_status_type statusLink;
  logic [2:0] bitCnt_q, bitCnt_d, curIdx;
  logic [7:0] shiftIn_q, shiftIn_d, txByte_q, txByte_d, sampled;
  logic [ADDR_W-1:0] addr_q, addr_d, addrNext;
  logic [PAGE_SIZE-1:0] pageValid_q, pageValid_d;
  logic frameNew_q, pageWe;
  logic soData_q, soData_d, soOe_q, soOe_d;
  sec_status_type statusByte_q, statusByte_d;

  // status levels change at a select rise or when a write cycle ends; a plain sync carries them
  sec_sync #(.WIDTH(8)) u_statusSync (
    .clk(sckClk),
    .din(statusByte_q),
    .dout(statusLink)
  );

  // first rising edge after select falls starts a fresh frame
  always_ff @(posedge sckClk or posedge csN) begin
    if (csN) begin
      frameNew_q <= 1'h1;
    end else if (holdN) begin
      frameNew_q <= 1'h0;
    end
  end

  always_comb begin
    sampled = {shiftIn_q[6:0], siData};
    curIdx = frameNew_q ? 3'h0 : bitCnt_q;
    curPhase = frameNew_q ? PH_OPC : phase_q;
    addrNext = ADDR_W'(addr_q + 1'h1);
    phase_d = phase_q;
    frame_d = frame_q;
    bitCnt_d = bitCnt_q;
    shiftIn_d = shiftIn_q;
    txByte_d = txByte_q;
    addr_d = addr_q;
    pageValid_d = pageValid_q;
    pageWe = 1'h0;
    if (holdN) begin
      phase_d = curPhase;
      bitCnt_d = 3'(curIdx + 3'h1);
      shiftIn_d = sampled;
      frame_d.byteEnd = 1'h0;
      if (frameNew_q) begin
        frame_d.opcode = 8'h00;
      end
      if (curIdx == 3'h7) begin
        case (curPhase)
          PH_OPC: begin
            frame_d.opcode = sampled;
            frame_d.byteEnd = (sampled == `SEC_OP_LATCH_SET) || (sampled == `SEC_OP_LATCH_CLR);
            if ((sampled == `SEC_OP_READ || sampled == `SEC_OP_WRITE) && !statusLink.busy) begin
              phase_d = PH_ADDR_HI;
              // slots clear only on an accepted access, so frames during a copy leave them
              pageValid_d = '0;
            end else if (sampled == `SEC_OP_STAT_READ) begin
              phase_d = PH_DATA;
              txByte_d = statusLink;
            end else if (sampled == `SEC_OP_STAT_WRITE) begin
              phase_d = PH_DATA;
            end else begin
              phase_d = PH_IGNORE;
            end
          end
          PH_ADDR_HI: begin
            addr_d[ADDR_W-1:8] = sampled[ADDR_W-9:0];
            phase_d = PH_ADDR_LO;
          end
          PH_ADDR_LO: begin
            addr_d[7:0] = sampled;
            phase_d = PH_DATA;
            txByte_d = mem[{addr_q[ADDR_W-1:8], sampled}];
          end
          PH_DATA: begin
            case (frame_q.opcode)
              `SEC_OP_READ: begin
                addr_d = addrNext;
                txByte_d = mem[addrNext];
              end
              `SEC_OP_STAT_READ: begin
                txByte_d = statusLink;
              end
              `SEC_OP_WRITE: begin
                pageWe = 1'h1;
                pageValid_d[addr_q[PAGE_W-1:0]] = 1'h1;
                addr_d[PAGE_W-1:0] = addrNext[PAGE_W-1:0];
                frame_d.byteEnd = 1'h1;
              end
              `SEC_OP_STAT_WRITE: begin
                frame_d.lastByte = sampled;
                frame_d.byteEnd = 1'h1;
              end
              default: begin
                phase_d = PH_IGNORE;
              end
            endcase
          end
          default: begin
            phase_d = PH_IGNORE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge sckClk or posedge rst) begin
    if (rst) begin
      phase_q <= PH_IGNORE;
      frame_q <= '0;
      bitCnt_q <= 3'h0;
      shiftIn_q <= 8'h00;
      txByte_q <= 8'h00;
      addr_q <= '0;
      pageValid_q <= '0;
    end else begin
      phase_q <= phase_d;
      frame_q <= frame_d;
      bitCnt_q <= bitCnt_d;
      shiftIn_q <= shiftIn_d;
      txByte_q <= txByte_d;
      addr_q <= addr_d;
      pageValid_q <= pageValid_d;
    end
  end

  always_ff @(posedge sckClk) begin
    if (pageWe) begin
      pageBuf[addr_q[PAGE_W-1:0]] <= sampled;
    end
  end

  // output changes after falling edges; select high releases it at once
  always_comb begin
    soOe_d = holdN && !frameNew_q && phase_q == PH_DATA &&
      (frame_q.opcode == `SEC_OP_READ || frame_q.opcode == `SEC_OP_STAT_READ);
    soData_d = txByte_q[3'h7 - bitCnt_q];
  end

  always_ff @(negedge sckClk or posedge csN) begin
    if (csN) begin
      soOe_q <= 1'h0;
      soData_q <= 1'h0;
    end else begin
      soOe_q <= soOe_d;
      soData_q <= soData_d;
    end
  end

  // ---------------- system clock domain ----------------
  sec_state_type state_q, state_d;
  logic csSync, wpSync, csPrev_q, csPrev_d, csRise, memWe;
  logic [PAGE_W:0] copyIdx_q, copyIdx_d;
  logic [TW-1:0] timer_q, timer_d;
  logic [ADDR_W-1:0] memAddr;

  sec_sync #(.WIDTH(2)) u_pinSync (
    .clk(clk_sys),
    .din({csN, wpN}),
    .dout({csSync, wpSync})
  );

  assign csRise = csSync && !csPrev_q;

  // frame results are read from the select rise until the copy ends; refused frames in that time leave them unchanged
  always_comb begin
    state_d = state_q;
    statusByte_d = statusByte_q;
    csPrev_d = csSync;
    copyIdx_d = copyIdx_q;
    timer_d = timer_q;
    memWe = 1'h0;
    memAddr = {addr_q[ADDR_W-1:PAGE_W], copyIdx_q[PAGE_W-1:0]};
    case (state_q)
      ST_IDLE: begin
        if (csRise && frame_q.byteEnd) begin
          if (frame_q.opcode == `SEC_OP_LATCH_SET) begin
            statusByte_d.write_latch_bit = 1'h1;
          end else if (frame_q.opcode == `SEC_OP_LATCH_CLR) begin
            statusByte_d.write_latch_bit = 1'h0;
          end else if (frame_q.opcode == `SEC_OP_STAT_WRITE && statusByte_q.write_latch_bit &&
                       !(statusByte_q.protect_pin_enable && !wpSync)) begin
            statusByte_d.bp = frame_q.lastByte[`SEC_SR_BP_HI:`SEC_SR_BP_LO];
            statusByte_d.protect_pin_enable = frame_q.lastByte[`SEC_SR_PROT_EN];
            statusByte_d.busy = 1'h1;
            timer_d = '0;
            state_d = ST_CYCLE;
          end else if (frame_q.opcode == `SEC_OP_WRITE && statusByte_q.write_latch_bit) begin
            statusByte_d.busy = 1'h1;
            copyIdx_d = '0;
            timer_d = '0;
            state_d = ST_COPY;
          end
        end
      end
      ST_COPY: begin
        memWe = pageValid_q[copyIdx_q[PAGE_W-1:0]] && !isProtected(memAddr, statusByte_q.bp);
        copyIdx_d = (PAGE_W + 1)'(copyIdx_q + 1'h1);
        timer_d = TW'(timer_q + 1'h1);
        if (copyIdx_q == (PAGE_W + 1)'(PAGE_SIZE - 1)) begin
          state_d = ST_CYCLE;
        end
      end
      default: begin
        timer_d = TW'(timer_q + 1'h1);
        if (timer_q == TW'(WRITE_CYCLES - 1)) begin
          statusByte_d.busy = 1'h0;
          statusByte_d.write_latch_bit = 1'h0;
          state_d = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= ST_IDLE;
      statusByte_q <= `SEC_STATUS_RST;
      csPrev_q <= 1'h1;
      copyIdx_q <= '0;
      timer_q <= '0;
    end else begin
      state_q <= state_d;
      statusByte_q <= statusByte_d;
      csPrev_q <= csPrev_d;
      copyIdx_q <= copyIdx_d;
      timer_q <= timer_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (memWe) begin
      mem[memAddr] <= pageBuf[copyIdx_q[PAGE_W-1:0]];
    end
  end

  assign soData = soData_q;
  assign soOe = soOe_q;
  assign writeBusyBit = statusByte_q.busy;
  assign writeLatchBit = statusByte_q.write_latch_bit;
  assign blockProtectLow = statusByte_q.bp[0];
  assign blockProtectHigh = statusByte_q.bp[1];
  assign protectPinEnable = statusByte_q.protect_pin_enable;

  // ---------------- checks ----------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence frameEnd;
    csRise && state_q == ST_IDLE && frame_q.byteEnd;
  endsequence

  sequence cycleDone;
    state_q == ST_CYCLE && timer_q == TW'(WRITE_CYCLES - 1);
  endsequence

  latchSet_a: assert property (
    frameEnd and (frame_q.opcode == `SEC_OP_LATCH_SET) |=> statusByte_q.write_latch_bit && !statusByte_q.busy)
    else $error("latch not set after set command");
  latchClear_a: assert property (
    frameEnd and (frame_q.opcode == `SEC_OP_LATCH_CLR) |=> !statusByte_q.write_latch_bit)
    else $error("latch not cleared after clear command");
  noLatchWrite_a: assert property (
    csRise && state_q == ST_IDLE && !statusByte_q.write_latch_bit |=> state_q == ST_IDLE && !statusByte_q.busy)
    else $error("write started without latch");
  partialByte_a: assert property (
    csRise && state_q == ST_IDLE && !frame_q.byteEnd |=> !statusByte_q.busy [*2])
    else $error("write committed on partial byte");
  cycleStart_a: assert property (
    frameEnd and (frame_q.opcode == `SEC_OP_WRITE && statusByte_q.write_latch_bit)
      |=> writeBusyBit && state_q == ST_COPY ##PAGE_SIZE state_q == ST_CYCLE)
    else $error("write cycle did not start or copy length wrong");
  cycleEnd_a: assert property (
    cycleDone |=> !writeBusyBit && !writeLatchBit && state_q == ST_IDLE)
    else $error("write cycle end did not clear busy and latch");
  busyTrack_a: assert property (
    $rose(writeBusyBit) |-> $past(state_q) == ST_IDLE && state_q != ST_IDLE)
    else $error("busy rose without a write cycle");
  protectCopy_a: assert property (
    memWe |-> !isProtected(memAddr, statusByte_q.bp) && statusByte_q.bp != 2'h3)
    else $error("protected address written");
  outReleased_a: assert property (
    csSync && csPrev_q && $past(csPrev_q) |-> !soOe)
    else $error("output driven while deselected");
  readWrap_a: assert property (@(posedge sckClk) disable iff (rst)
    holdN && !frameNew_q && phase_q == PH_DATA && frame_q.opcode == `SEC_OP_READ &&
      bitCnt_q == 3'h7 && addr_q == '1 |=> addr_q == '0)
    else $error("read pointer did not wrap");
  pageWrap_a: assert property (@(posedge sckClk) disable iff (rst)
    pageWe |=> addr_q[ADDR_W-1:PAGE_W] == $past(addr_q[ADDR_W-1:PAGE_W]) &&
      addr_q[PAGE_W-1:0] == PAGE_W'($past(addr_q[PAGE_W-1:0]) + 1'h1))
    else $error("page write left its page");
  holdFreeze_a: assert property (@(posedge sckClk) disable iff (rst)
    !holdN && !frameNew_q |=> $stable(bitCnt_q) && $stable(phase_q) && $stable(addr_q))
    else $error("transfer moved during pause");
endmodule : sec_core

// ===== core/sec_params.svh
// constants for the serial eeprom command core
// Notes on behaviour
// - 8-bit opcode register, six instructions decoded
// - input sampled on rising serial clock edges
// - all bytes travel most significant bit first
// - pause freezes transfer, release resumes it; output drive returns only at the first falling edge after release
// - read: opcode, 16-bit address, top two ignored
// - read pointer increments, wraps 3FFFh to 0000h
// - select rising ends any read
// - latch sets only on select rise after opcode
// - write: opcode, address, 1 to 64 bytes
// - page overflow wraps to page start
// - commit only when select rises after byte
// - status readable while busy, array not
// - finished write cycle clears the latch
// - set and clear latch opcodes
// - no write without latch set
// - latch cleared at reset and after writes
// - busy bit one during write cycle only
// - block protect codes guard none to all
// - write cycle starts at select rise, 5 ms
// - output released while select is high
`ifndef SEC_PARAMS_SVH
`define SEC_PARAMS_SVH

`define SEC_OP_READ 8'h03
`define SEC_OP_WRITE 8'h02
`define SEC_OP_LATCH_CLR 8'h04
`define SEC_OP_LATCH_SET 8'h06
`define SEC_OP_STAT_READ 8'h05
`define SEC_OP_STAT_WRITE 8'h01

`define SEC_ADDR_W 14
`define SEC_PAGE_W 6
`define SEC_QTR_BASE 14'h3000
`define SEC_HALF_BASE 14'h2000
`define SEC_STATUS_RST 8'h00
`define SEC_SR_PROT_EN 7
`define SEC_SR_BP_HI 3
`define SEC_SR_BP_LO 2

`define SEC_TWC_NS 5000000
`define SEC_CLK_NS 10

`endif

// ===== core/sec_pkg.sv
// types shared by the serial eeprom command core
`include "sec_params.svh"
package sec_pkg;

  typedef enum logic [2:0] {PH_OPC, PH_ADDR_HI, PH_ADDR_LO, PH_DATA, PH_IGNORE} sec_phase_type;

  typedef enum logic [1:0] {ST_IDLE, ST_COPY, ST_CYCLE} sec_state_type;

  typedef struct packed {
    logic protect_pin_enable;
    logic [2:0] spare;
    logic [1:0] bp;
    logic write_latch_bit;
    logic busy;
  } sec_status_type;

  typedef struct packed {
    logic [7:0] opcode;
    logic byteEnd;
    logic [7:0] lastByte;
  } sec_frame_type;

endpackage : sec_pkg

// ===== core/sec_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
module sec_sync #(
  parameter int WIDTH = 1
) (
  // clock
  input wire logic clk,
  // levels
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk) begin
    meta_q <= din;
    dout <= meta_q;
  end
endmodule : sec_sync

// ===== testbench/sec_spi_master.sv
// serial link master model driving the eeprom core's pins
`timescale 1ns/1ps
module sec_spi_master (
  // link out
  output logic sckClk,
  output logic csN,
  output logic siData,
  output logic holdN,
  // link in
  input wire logic soData,
  input wire logic soOe
);
  localparam time HALF = 80ns;
  logic oeSeen;
  initial begin
    sckClk = 1'b0;
    csN = 1'b0;
    siData = 1'b0;
    holdN = 1'b1;
    oeSeen = 1'b0;
    // a real rising edge, so the select-cleared flops leave their unknown state
    #1 csN = 1'b1;
  end
  task automatic start_frame();
    oeSeen = 1'b0;
    #37 csN = 1'b0; // select stays low for the whole operation
    #HALF;
  endtask : start_frame
  task automatic xfer(input logic [7:0] tx, input int holdAt, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      siData = tx[i]; // most significant bit first
      if (i == holdAt) begin
        holdN = 1'b0;
        // garbage clocks while paused must be ignored
        repeat (2) begin
          #HALF sckClk = 1'b1;
          siData = ~siData;
          #HALF sckClk = 1'b0;
        end
        holdN = 1'b1;
        siData = tx[i];
      end
      #HALF sckClk = 1'b1; // sampled on the rise
      // undriven line reads back inverted, so a released output cannot pass
      rx[i] = soOe ? soData : ~soData;
      oeSeen = oeSeen | soOe;
      #HALF sckClk = 1'b0;
    end
  endtask : xfer
  task automatic end_frame();
    #HALF csN = 1'b1;
    // released data line must not look like a held value
    siData = ~siData;
    #200;
  endtask : end_frame
endmodule : sec_spi_master

// ===== testbench/spi_eeprom_command_core_tb.sv
// self-checking bench for the serial eeprom command core
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin bad_count++; \
  $display("BAD %s expected %h seen %h", nm, exp, got); end end
module spi_eeprom_command_core_tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b0;
  logic wpN = 1'b1;
  logic sckClk, csN, siData, holdN, soData, soOe;
  logic busy, latch, bpLow, bpHigh, pinEn;
  logic [7:0] rx;
  logic [7:0] rb [4];
  int bad_count = 0;
  int cmp_count = 0;

  // write cycle long enough for a status read and a refused read inside it
  sec_core #(.WRITE_CYCLES(1000)) uut (.clk_sys(clk_sys), .rst(rst), .sckClk(sckClk),
    .csN(csN), .siData(siData), .holdN(holdN), .wpN(wpN), .soData(soData), .soOe(soOe),
    .writeBusyBit(busy), .writeLatchBit(latch), .blockProtectLow(bpLow),
    .blockProtectHigh(bpHigh), .protectPinEnable(pinEn));
  sec_spi_master link (.sckClk(sckClk), .csN(csN), .siData(siData), .holdN(holdN),
    .soData(soData), .soOe(soOe));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  task automatic cmd(input logic [7:0] op, input logic [7:0] arg, input int n);
    link.start_frame();
    link.xfer(op, -1, rx);
    if (n > 0) begin
      link.xfer(arg, -1, rx);
    end
    link.end_frame();
  endtask : cmd

  task automatic wr(input logic [15:0] a, input int n, input logic [7:0] d0,
                    input logic [7:0] d1, input logic [7:0] d2, input int holdAt);
    logic [7:0] d [3];
    d = '{d0, d1, d2};
    link.start_frame();
    link.xfer(8'h02, -1, rx);
    link.xfer(a[15:8], -1, rx);
    link.xfer(a[7:0], -1, rx);
    for (int k = 0; k < n; k++) begin
      link.xfer(d[k], (k == 0) ? holdAt : -1, rx);
    end
    link.end_frame();
  endtask : wr

  task automatic rd(input logic [15:0] a, input int n);
    link.start_frame();
    link.xfer(8'h03, -1, rx);
    link.xfer(a[15:8], -1, rx);
    link.xfer(a[7:0], -1, rx);
    for (int k = 0; k < n; k++) begin
      link.xfer(8'h00, -1, rb[k]);
    end
    link.end_frame();
  endtask : rd

  task automatic wait_idle();
    int t;
    t = 0;
    while (busy !== 1'b0 && t < 2000) begin
      @(posedge clk_sys);
      t++;
    end
    if (t >= 2000) begin
      bad_count++;
      conclude();
    end
  endtask : wait_idle

  initial begin
    #800us;
    bad_count++;
    conclude();
  end

  initial begin
    rst <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    `CHK("latch", 1'b0, latch)
    `CHK("busy", 1'b0, busy)
    `CHK("oe", 1'b0, soOe)
    cmd(8'h06, 8'h00, 0);
    `CHK("latch", 1'b1, latch)
    cmd(8'h04, 8'h00, 0);
    `CHK("latch", 1'b0, latch)
    // write behind the enable opcode in the same frame
    link.start_frame();
    link.xfer(8'h06, -1, rx);
    link.xfer(8'h02, -1, rx);
    link.xfer(8'h00, -1, rx);
    link.xfer(8'h10, -1, rx);
    link.xfer(8'h77, -1, rx);
    link.end_frame();
    `CHK("busy", 1'b0, busy)
    cmd(8'h04, 8'h00, 0);
    // page overflow from the last two slots
    cmd(8'h06, 8'h00, 0);
    wr(16'h003E, 3, 8'hA0, 8'hA1, 8'hA2, -1);
    `CHK("busy", 1'b1, busy)
    cmd(8'h05, 8'h00, 1);
    `CHK("status", 8'h03, rx)
    `CHK("oe", 1'b1, link.oeSeen)
    rd(16'h003E, 1);
    `CHK("oe", 1'b0, link.oeSeen)
    wait_idle();
    `CHK("latch", 1'b0, latch)
    rd(16'hC03E, 2);
    `CHK("rd0", 8'hA0, rb[0])
    `CHK("rd1", 8'hA1, rb[1])
    `CHK("oe", 1'b0, soOe)
    rd(16'h0000, 1);
    `CHK("wrap", 8'hA2, rb[0])
    cmd(8'h05, 8'h00, 1);
    `CHK("status", 8'h00, rx)
    wr(16'h0001, 1, 8'h55, 8'h00, 8'h00, -1);
    `CHK("busy", 1'b0, busy)
    // no data byte before the select rise
    cmd(8'h06, 8'h00, 0);
    link.start_frame();
    link.xfer(8'h02, -1, rx);
    link.xfer(8'h00, -1, rx);
    link.xfer(8'h05, -1, rx);
    link.end_frame();
    `CHK("busy", 1'b0, busy)
    `CHK("latch", 1'b1, latch)
    wr(16'h3FFF, 1, 8'h5A, 8'h00, 8'h00, 4);
    wait_idle();
    rd(16'h3FFF, 2);
    `CHK("hold", 8'h5A, rb[0])
    `CHK("top", 8'hA2, rb[1])
    cmd(8'h06, 8'h00, 0);
    cmd(8'h01, 8'h04, 1);
    wait_idle();
    `CHK("bp0", 1'b1, bpLow)
    `CHK("bp1", 1'b0, bpHigh)
    `CHK("latch", 1'b0, latch)
    cmd(8'h06, 8'h00, 0);
    wr(16'h3FFF, 1, 8'h11, 8'h00, 8'h00, -1);
    wait_idle();
    rd(16'h3FFF, 1);
    `CHK("prot", 8'h5A, rb[0])
    cmd(8'h06, 8'h00, 0);
    cmd(8'h01, 8'h84, 1);
    wait_idle();
    `CHK("protect_pin_enable", 1'b1, pinEn)
    `CHK("latch", 1'b0, latch)
    // pin low with the enable set refuses a status write
    @(posedge clk_sys);
    wpN <= 1'b0;
    cmd(8'h06, 8'h00, 0);
    cmd(8'h01, 8'h00, 1);
    `CHK("busy", 1'b0, busy)
    `CHK("bp0", 1'b1, bpLow)
    `CHK("protect_pin_enable", 1'b1, pinEn)
    `CHK("latch", 1'b1, latch)
    conclude();
  end
endmodule : spi_eeprom_command_core_tb
